// ==== ltcw_pin_model.sv ====
// capture pin source on the far side
// assumes flip is a one-cycle request from the bench
`timescale 1ns/1ps
module ltcw_pin_model (
	input  wire logic pclk,
	input  wire logic flip,
	output      logic capture_pin
);
	initial capture_pin = 1'b0;
	always @(posedge pclk) if (flip) capture_pin <= ~capture_pin;
endmodule

// ==== ltcw_pkg.sv ====
// register map, field layout, reset values and timing counts of the lite timebase, capture and watchdog block
// assumes a 200 MHz pclk and a 32-bit APB master; offsets are register indices, byte address is index times four
// Contract
// - counter 1 counts up from zero at osc/32 after reset, no software access
// - counter 1 overflows when it wraps from F9h to 00h, modulo 250
// - period select clear gives 8000 osc periods, set gives 16000
// - each counter 1 overflow sets first timebase flag; interrupt when enabled (code: with period select set only every second overflow sets it)
// - reading first control/status clears first timebase flag; writes leave it alone
// - any edge on capture pin copies counter 1 into capture value, sets flag
// - capture blocked while flag set; reading capture value clears flag; writes ignored
// - capture interrupt requested while capture flag and its enable are set
// - counter 2 counts up at osc/32 from reload value after reset; readable
// - counter 2 overflows past FFh and reloads from the reload register
// - reload register writable anytime; takes effect at next counter 2 overflow
// - counter 2 overflow sets second flag; read of second status clears it
// - enabled watchdog resets the device 2 ms after the last refresh
// - software sets refresh bit periodically; hardware clears it after each interval
// - setting forced-reset bit causes an immediate watchdog reset
// - forced-reset bit reads as watchdog-reset-source flag, cleared after being read
// - hardware watchdog option keeps watchdog active, ignoring software enable
// - halt without reset-on-halt stops counting; wakeup restarts watchdog after 4096 clocks
// - slow, wait and active-halt do not stop the timer; only full halt does
// - three separate interrupt lines, each high while its flag and enable set
package ltcw_pkg;
	localparam logic [7:0] LTCW_IDX_TB2_CS   = 8'h0c;
	localparam logic [7:0] LTCW_IDX_RELOAD   = 8'h0d;
	localparam logic [7:0] LTCW_IDX_CNT2     = 8'h0e;
	localparam logic [7:0] LTCW_IDX_TB1_CS   = 8'h0f;
	localparam logic [7:0] LTCW_IDX_CAPTURE  = 8'h10;
	localparam logic [7:0] LTCW_IDX_WDG_CTRL = 8'h11;

	localparam int LTCW_TB2_IE_BIT  = 1;
	localparam int LTCW_TB2_F_BIT   = 0;
	localparam int LTCW_CAP_IE_BIT  = 7;
	localparam int LTCW_CAP_F_BIT   = 6;
	localparam int LTCW_PSEL_BIT    = 5;
	localparam int LTCW_TB1_IE_BIT  = 4;
	localparam int LTCW_TB1_F_BIT   = 3;
	localparam int LTCW_WDG_EN_BIT  = 0;
	localparam int LTCW_WDG_REF_BIT = 1;
	localparam int LTCW_WDG_RF_BIT  = 2;

	localparam logic [7:0] LTCW_RST_BYTE  = 8'h00;
	localparam logic [7:0] LTCW_CNT1_LAST = 8'hf9;
	localparam logic [7:0] LTCW_CNT2_LAST = 8'hff;

	localparam int          LTCW_OSC_DIV       = 32;
	localparam logic [4:0]  LTCW_OSC_DIV_LAST  = 5'h1f;
	localparam int          LTCW_WDG_MS        = 2;
	localparam int          LTCW_OSC_KHZ       = 8000;
	localparam int          LTCW_WDG_TICKS     = LTCW_WDG_MS * LTCW_OSC_KHZ / LTCW_OSC_DIV;
	localparam int          LTCW_WAKE_CPU_CLKS = 4096;

	typedef struct packed {
		logic [7:0] cnt1;
		logic       tb1_half;
		logic [7:0] cnt2;
		logic [7:0] reload;
		logic [7:0] capture;
		logic       cap_flag;
		logic       cap_ie;
		logic       psel;
		logic       tb1_ie;
		logic       tb1_flag;
		logic       tb2_ie;
		logic       tb2_flag;
		logic       wdg_en;
		logic       wdg_ref;
		logic       wdg_rf;
		logic [8:0] wdg_cnt;
		logic [12:0] wake_cnt;
		logic       pin_s1;
		logic       pin_s2;
		logic       pin_s3;
		logic       halt_s1;
		logic       halt_s2;
		logic       halted_q;
		logic       wdg_rst;
		logic       irq_tb1;
		logic       irq_tb2;
		logic       irq_cap;
		logic       pready;
		logic [31:0] prdata;
	} ltcw_state_t;
endpackage

// ==== ltcw_timer.sv ====
// lite timebase counters, capture register and watchdog behind an APB slave
// assumes pclk stands in for the oscillator; osc/32 tick comes from a divider of pclk
`timescale 1ns/1ps
module ltcw_timer
	import ltcw_pkg::*;
#(
	parameter int WAKE_DELAY = LTCW_WAKE_CPU_CLKS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	input  wire logic        capture_pin,
	input  wire logic        halt_req,
	input  wire logic        hw_watchdog_opt,
	output      logic        irq_tb1,
	output      logic        irq_tb2,
	output      logic        irq_cap,
	output      logic        watchdog_reset
);
	ltcw_state_t s_q;
	ltcw_state_t s_d;
	logic [4:0]  div_q;
	logic [4:0]  div_d;

	logic        setup;
	logic        wr;
	logic        rd;
	logic [7:0]  idx;
	logic        mapped;
	logic        tick;
	logic        running;
	logic        wdg_active;
	logic        cnt1_ovf;
	logic        cnt2_ovf;
	logic        pin_edge;
	logic [7:0]  rbyte;

	always_comb begin
		setup  = psel && !penable;
		wr     = setup && pwrite;
		rd     = setup && !pwrite;
		idx    = paddr[9:2];
		mapped = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h0) &&
			(idx >= LTCW_IDX_TB2_CS) && (idx <= LTCW_IDX_WDG_CTRL);
		// halt stops the divider itself, lower power modes are not seen here
		running    = !s_q.halted_q;
		tick       = running && (div_q == LTCW_OSC_DIV_LAST);
		div_d      = running ? div_q + 5'd1 : div_q;
		wdg_active = (hw_watchdog_opt || s_q.wdg_en) && (s_q.wake_cnt == 13'd0);
		cnt1_ovf   = tick && (s_q.cnt1 == LTCW_CNT1_LAST);
		cnt2_ovf   = tick && (s_q.cnt2 == LTCW_CNT2_LAST);
		pin_edge   = s_q.pin_s2 ^ s_q.pin_s3;
		unique case (idx)
			LTCW_IDX_TB2_CS: begin
				rbyte = {6'h00, s_q.tb2_ie, s_q.tb2_flag};
			end
			LTCW_IDX_RELOAD: begin
				rbyte = s_q.reload;
			end
			LTCW_IDX_CNT2: begin
				rbyte = s_q.cnt2;
			end
			LTCW_IDX_TB1_CS: begin
				rbyte = {s_q.cap_ie, s_q.cap_flag, s_q.psel, s_q.tb1_ie, s_q.tb1_flag, 3'h0};
			end
			LTCW_IDX_CAPTURE: begin
				rbyte = s_q.capture;
			end
			LTCW_IDX_WDG_CTRL: begin
				rbyte = {5'h00, s_q.wdg_rf, s_q.wdg_ref, s_q.wdg_en};
			end
			default: begin
				rbyte = 8'h00;
			end
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.pin_s1  = capture_pin;
		s_d.pin_s2  = s_q.pin_s1;
		s_d.pin_s3  = s_q.pin_s2;
		s_d.halt_s1 = halt_req;
		s_d.halt_s2 = s_q.halt_s1;
		s_d.halted_q = s_q.halt_s2;
		s_d.pready  = setup;
		s_d.prdata  = (rd && mapped) ? {24'h0, rbyte} : 32'h0;
		s_d.wdg_rst = 1'b0;

		// wakeup from halt: the watchdog waits before counting again
		if (s_q.halted_q && !s_q.halt_s2) begin
			s_d.wake_cnt = WAKE_DELAY[12:0];
		end else if (s_q.wake_cnt != 13'd0) begin
			s_d.wake_cnt = s_q.wake_cnt - 13'd1;
		end

		// counter 1: two passes of 250 ticks form the doubled period
		if (tick) begin
			s_d.cnt1 = cnt1_ovf ? 8'h00 : s_q.cnt1 + 8'd1;
		end
		if (cnt1_ovf) begin
			s_d.tb1_half = !s_q.tb1_half;
		end
		if (tick) begin
			s_d.cnt2 = cnt2_ovf ? s_q.reload : s_q.cnt2 + 8'd1;
		end

		// register writes; timebase and capture flag bits ignore writes
		if (wr && mapped) begin
			unique case (idx)
				LTCW_IDX_TB2_CS: begin
					s_d.tb2_ie = pwdata[LTCW_TB2_IE_BIT];
				end
				LTCW_IDX_RELOAD: begin
					s_d.reload = pwdata[7:0];
				end
				LTCW_IDX_TB1_CS: begin
					s_d.cap_ie = pwdata[LTCW_CAP_IE_BIT];
					s_d.psel   = pwdata[LTCW_PSEL_BIT];
					s_d.tb1_ie = pwdata[LTCW_TB1_IE_BIT];
				end
				LTCW_IDX_WDG_CTRL: begin
					s_d.wdg_en = s_q.wdg_en | pwdata[LTCW_WDG_EN_BIT];
					if (pwdata[LTCW_WDG_REF_BIT]) begin
						s_d.wdg_ref = 1'b1;
					end
					if (pwdata[LTCW_WDG_RF_BIT]) begin
						s_d.wdg_rst = 1'b1;
						s_d.wdg_rf  = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// read-to-clear, then hardware sets so a same-cycle timebase or watchdog event wins
		if (rd && mapped && idx == LTCW_IDX_TB1_CS) begin
			s_d.tb1_flag = 1'b0;
		end
		if (rd && mapped && idx == LTCW_IDX_TB2_CS) begin
			s_d.tb2_flag = 1'b0;
		end
		if (rd && mapped && idx == LTCW_IDX_CAPTURE) begin
			s_d.cap_flag = 1'b0;
		end
		if (rd && mapped && idx == LTCW_IDX_WDG_CTRL && !(wr && pwdata[LTCW_WDG_RF_BIT])) begin
			s_d.wdg_rf = 1'b0;
		end
		if (cnt1_ovf && (s_q.tb1_half || !s_q.psel)) begin
			s_d.tb1_flag = 1'b1;
		end
		if (cnt2_ovf) begin
			s_d.tb2_flag = 1'b1;
		end
		if (pin_edge && !s_q.cap_flag) begin
			s_d.capture  = s_q.cnt1;
			s_d.cap_flag = 1'b1;
		end

		// watchdog interval; refresh is consumed at the end of each interval
		if (!wdg_active) begin
			s_d.wdg_cnt = 9'd0;
		end else if (tick) begin
			if (s_q.wdg_cnt == 9'(LTCW_WDG_TICKS - 1)) begin
				s_d.wdg_cnt = 9'd0;
				s_d.wdg_ref = 1'b0;
				if (!s_q.wdg_ref) begin
					s_d.wdg_rst = 1'b1;
					s_d.wdg_rf  = 1'b1;
				end
			end else begin
				s_d.wdg_cnt = s_q.wdg_cnt + 9'd1;
			end
		end

		s_d.irq_tb1 = s_d.tb1_flag && s_d.tb1_ie;
		s_d.irq_tb2 = s_d.tb2_flag && s_d.tb2_ie;
		s_d.irq_cap = s_d.cap_flag && s_d.cap_ie;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q   <= '0;
			div_q <= 5'd0;
		end else begin
			s_q   <= s_d;
			div_q <= div_d;
		end
	end

	assign prdata         = s_q.prdata;
	assign pready         = s_q.pready;
	assign pslverr        = 1'b0;
	assign irq_tb1        = s_q.irq_tb1;
	assign irq_tb2        = s_q.irq_tb2;
	assign irq_cap        = s_q.irq_cap;
	assign watchdog_reset = s_q.wdg_rst;
endmodule

// ==== ltcw_timer_checker.sv ====
// port assertions for ltcw_timer
// assumes a bind to ltcw_timer, one pclk domain
`timescale 1ns/1ps
module ltcw_timer_checker
	import ltcw_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        halt_req,
	input wire logic        irq_tb1,
	input wire logic        irq_cap,
	input wire logic        watchdog_reset
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup(i, w); psel && !penable && pwrite == w && paddr[9:2] == i; endsequence
	a_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no ready");
	a_data_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("stray read data");
	a_unmapped_zero: assert property (s_setup(8'h20, 0) |=> pready && prdata == 32'h0)
		else $error("unmapped read");
	a_pulse_single: assert property ($rose(watchdog_reset) |=> !watchdog_reset)
		else $error("long reset pulse");
	a_force_reset: assert property (s_setup(LTCW_IDX_WDG_CTRL, 1) ##0 pwdata[LTCW_WDG_RF_BIT] |-> ##[1:3] watchdog_reset)
		else $error("no forced reset");
	a_cap_clear: assert property (s_setup(LTCW_IDX_CAPTURE, 0) |-> ##2 !irq_cap)
		else $error("capture irq kept");
	a_tb1_clear: assert property (s_setup(LTCW_IDX_TB1_CS, 0) |-> ##2 !irq_tb1)
		else $error("timebase irq kept");
	// six cycles leave room for the halt synchroniser
	a_halt_quiet: assert property (halt_req [*6] |-> !watchdog_reset)
		else $error("reset in halt");
endmodule

// ==== ltcw_timer_tb.sv ====
// bench for ltcw_timer: rows, capture, timebases, watchdog, reset
// assumes ltcw_pin_model on the pin and the checker bound below
`timescale 1ns/1ps
module ltcw_timer_tb
	import ltcw_pkg::*;
;
	typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] ex;} ltcw_row_t;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, halt_req = 1'b0, flip = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
	logic        pready, capture_pin, irq_tb1, irq_tb2, irq_cap, watchdog_reset;
	logic [7:0]  c1;
	int          n_errors = 0, checked = 0, cyc = 0, n_wdg = 0, t0;
	ltcw_row_t   rows [6] = '{'{8'h10, 8'h5a, 8'h00}, '{8'h0c, 8'h03, 8'h02}, '{8'h0d, 8'ha5, 8'ha5},
		'{8'h0f, 8'hf8, 8'hb0}, '{8'h20, 8'hff, 8'h00}, '{8'h0f, 8'h80, 8'h80}};
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;
	always @(posedge pclk) if (watchdog_reset === 1'b1) n_wdg <= n_wdg + 1;
	ltcw_timer #(.WAKE_DELAY(8)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr(), .capture_pin, .halt_req, .hw_watchdog_opt(1'b0), .irq_tb1, .irq_tb2, .irq_cap,
		.watchdog_reset);
	ltcw_pin_model pin (.pclk, .flip, .capture_pin);
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	// idle edge first, so psel is never driven twice in one step
	task automatic apb(logic w, logic [7:0] i, logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {22'h0, i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic edge_at(int t);
		wait (cyc == t);
		flip <= 1'b1;
		@(posedge pclk);
		flip <= 1'b0;
	endtask
	// time up to the first rise after a change may be partial, so the gap is timed from that rise to the next
	task automatic period(logic [7:0] i, int ex);
		int t;
		apb(1'b0, i, 8'h00);
		@(posedge (i == LTCW_IDX_TB2_CS ? irq_tb2 : irq_tb1));
		#1 t = cyc;
		apb(1'b0, i, 8'h00);
		@(posedge (i == LTCW_IDX_TB2_CS ? irq_tb2 : irq_tb1));
		#1 chk("period", 32'(ex), 32'(cyc - t));
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		// worst case of all scenarios is near 88k cycles; stay below 100k
		#475000;
		n_errors++;
		$display("wrong value run expected end seen hang");
		print_verdict();
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[k]) begin
			apb(1'b1, rows[k].idx, rows[k].wd);
			apb(1'b0, rows[k].idx, 8'h00);
			chk("row", {24'h0, rows[k].ex}, rd);
		end
		$display("rows done");
		t0 = cyc + 4;
		edge_at(t0);
		edge_at(t0 + 64);
		repeat (8) @(posedge pclk);
		chk("irq_cap", 32'h1, {31'h0, irq_cap});
		apb(1'b0, LTCW_IDX_CAPTURE, 8'h00);
		c1 = rd[7:0];
		edge_at(t0 + 640);
		repeat (8) @(posedge pclk);
		apb(1'b0, LTCW_IDX_CAPTURE, 8'h00);
		chk("capture", 32'((c1 + 20) % 250), rd);
		$display("capture done");
		apb(1'b1, LTCW_IDX_TB1_CS, 8'h10);
		period(LTCW_IDX_TB1_CS, 8000);
		apb(1'b1, LTCW_IDX_TB1_CS, 8'h30);
		period(LTCW_IDX_TB1_CS, 16000);
		period(LTCW_IDX_TB2_CS, 2912);
		apb(1'b0, LTCW_IDX_CNT2, 8'h00);
		chk("cnt2", 32'h1, {31'h0, rd[7:0] >= 8'ha5});
		$display("timebases done");
		apb(1'b1, LTCW_IDX_WDG_CTRL, 8'h04);
		apb(1'b0, LTCW_IDX_WDG_CTRL, 8'h00);
		chk("forced", 32'h1, 32'(n_wdg));
		chk("source", 32'h4, rd & 32'h4);
		apb(1'b0, LTCW_IDX_WDG_CTRL, 8'h00);
		chk("source clr", 32'h0, rd & 32'h4);
		// refresh left out before halt on purpose, so the post-wake reset shows
		apb(1'b1, LTCW_IDX_WDG_CTRL, 8'h01);
		halt_req <= 1'b1;
		repeat (16200) @(posedge pclk);
		chk("halt", 32'h1, 32'(n_wdg));
		halt_req <= 1'b0;
		repeat (16500) @(posedge pclk);
		chk("wdg", 32'h1, {31'h0, n_wdg > 1});
		$display("watchdog done");
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("rst out", 32'h0, {28'h0, irq_tb1, irq_tb2, irq_cap, watchdog_reset});
		presetn <= 1'b1;
		apb(1'b0, LTCW_IDX_WDG_CTRL, 8'h00);
		chk("wdg rst", 32'h0, rd);
		$display("reset done");
		print_verdict();
	end
endmodule
bind ltcw_timer ltcw_timer_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .halt_req, .irq_tb1, .irq_cap, .watchdog_reset);
